// *** design/cmd_frame_defines.vh ***
// Constants for the command frame parser: frame layout, status codes.
// Assumes inclusion by bare name from design files.
`ifndef CMD_FRAME_DEFINES_VH
`define CMD_FRAME_DEFINES_VH
`define FRAME_LEN_SERIAL   4'h9
`define FRAME_LEN_CAN      4'h7
`define REPLY_LEN          4'h9
`define STATUS_OK          8'h64
`define STATUS_BAD_SUM     8'h01
`define DEFAULT_MODULE_ADR 8'h01
`define DEFAULT_REPLY_ADR  8'h02
`endif

// *** design/byte_fifo.v ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             clock,
	input  wire             reset_n,
	// Fill side
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	// Drain side
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0]    wrPtr;
	reg [AW-1:0]    rdPtr;
	reg [AW:0]      count;
	wire            doWrite;
	wire            doRead;

	assign inReady  = (count != DEPTH[AW:0]);
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData  = store[rdPtr];
	assign doWrite  = inValid & inReady;
	assign doRead   = outValid & outReady;

	always @(posedge clock) begin
		if (doWrite) begin
			store[wrPtr] <= inData;
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (doWrite)
				wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: wrPtr + 1'b1;
			if (doRead)
				rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: rdPtr + 1'b1;
			if (doWrite & ~doRead)
				count <= count + 1'b1;
			else if (doRead & ~doWrite)
				count <= count - 1'b1;
		end
	end
endmodule // byte_fifo

// *** design/motion_command_frame_parser.v ***
// Command frame parser: receives byte frames, checks address and sum of serial frames, hands the
// decoded command out, and sends one reply per accepted command.
// Assumes rx bytes arrive as same-clock strobes from a byte UART/USB core.
`timescale 1ns/1ps
`include "cmd_frame_defines.vh"
module motion_command_frame_parser #(
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW    = 3
) (
	// Clock and reset
	input  wire        clock,
	input  wire        reset_n,
	// Configuration
	input  wire        canMode,
	input  wire [7:0]  moduleAddress,
	input  wire [7:0]  replyAddress,
	// Received bytes
	input  wire        rxValid,
	input  wire [7:0]  rxByte,
	// Decoded command to executor
	output reg         cmdValid,
	output reg  [7:0]  cmdInstruction,
	output reg  [7:0]  cmdType,
	output reg  [7:0]  cmdAxis,
	output reg  [31:0] cmdOperand,
	// Execution result
	input  wire        doneValid,
	input  wire [7:0]  doneStatus,
	input  wire [31:0] doneValue,
	// Transmit bytes
	output wire        txValid,
	input  wire        txReady,
	output wire [7:0]  txByte,
	output reg         txEnable,
	// Status
	output reg         busy,
	output reg         checksumError
);
	// Binary state codes
	localparam RECEIVE = 2'h0;
	localparam EXECUTE = 2'h1;
	localparam REPLY   = 2'h2;
	localparam DRAIN   = 2'h3;

	reg [1:0]  state;
	reg [3:0]  rxCount;
	reg [7:0]  rxSum;
	reg [7:0]  rxAddr;
	reg [3:0]  txCount;
	reg [7:0]  txSum;
	reg [7:0]  replyStatus;
	reg [31:0] replyValue;
	reg [7:0]  next_txByte;
	reg        fifoValid;
	wire       fifoReady;
	wire       fifoOutValid;
	wire [3:0] frameLen;
	wire [3:0] coreIdx;
	wire [3:0] replyLen;
	wire       lastByte;
	wire [3:0] replyIdx;

	// CAN frames skip address and checksum bytes
	assign frameLen = canMode ? `FRAME_LEN_CAN : `FRAME_LEN_SERIAL;
	assign coreIdx  = canMode ? rxCount : rxCount - 4'h1;
	assign replyLen = canMode ? `FRAME_LEN_CAN : `REPLY_LEN;
	assign lastByte = (rxCount == frameLen - 4'h1);
	// CAN replies drop the reply address and the sum: the CAN identifier
	// stands in for the one and the bus CRC for the other
	assign replyIdx = canMode ? txCount + 4'h1 : txCount;

	// Reply byte selection, numbered in serial positions
	function [7:0] replyField;
		input [3:0]  idx;
		input [7:0]  rAdr;
		input [7:0]  mAdr;
		input [7:0]  stat;
		input [7:0]  ins;
		input [31:0] val;
		input [7:0]  sum;
		begin
			case (idx)
				4'h0: replyField = rAdr;
				4'h1: replyField = mAdr;
				4'h2: replyField = stat;
				4'h3: replyField = ins;
				4'h4: replyField = val[31:24];
				4'h5: replyField = val[23:16];
				4'h6: replyField = val[15:8];
				4'h7: replyField = val[7:0];
				default: replyField = sum;
			endcase
		end
	endfunction

	always @* begin
		next_txByte = replyField(replyIdx, replyAddress, moduleAddress,
			replyStatus, cmdInstruction, replyValue, txSum);
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state          <= RECEIVE;
			rxCount        <= 4'h0;
			rxSum          <= 8'h00;
			rxAddr         <= 8'h00;
			txCount        <= 4'h0;
			txSum          <= 8'h00;
			replyStatus    <= 8'h00;
			replyValue     <= 32'h00000000;
			fifoValid      <= 1'b0;
			cmdValid       <= 1'b0;
			cmdInstruction <= 8'h00;
			cmdType        <= 8'h00;
			cmdAxis        <= 8'h00;
			cmdOperand     <= 32'h00000000;
			txEnable       <= 1'b0;
			busy           <= 1'b0;
			checksumError  <= 1'b0;
		end else begin
			cmdValid      <= 1'b0;
			checksumError <= 1'b0;
			case (state)
				RECEIVE: begin
					txEnable <= 1'b0;
					if (rxValid) begin
						rxSum <= rxSum + rxByte;
						if (!canMode && rxCount == 4'h0)
							rxAddr <= rxByte;
						case (coreIdx)
							4'h0: cmdInstruction <= rxByte;
							4'h1: cmdType <= rxByte;
							4'h2: cmdAxis <= rxByte;
							4'h3: cmdOperand[31:24] <= rxByte;
							4'h4: cmdOperand[23:16] <= rxByte;
							4'h5: cmdOperand[15:8] <= rxByte;
							4'h6: cmdOperand[7:0] <= rxByte;
							default: ;
						endcase
						// rxSum has not taken the sum byte, so it is the expected sum
						if (lastByte) begin
							rxCount <= 4'h0;
							rxSum   <= 8'h00;
							if (!canMode && rxAddr != moduleAddress) begin
								state <= RECEIVE;
							end else if (!canMode && rxByte != rxSum) begin
								// Bad sum: reply at once, no execution
								replyStatus   <= `STATUS_BAD_SUM;
								replyValue    <= 32'h00000000;
								checksumError <= 1'b1;
								busy          <= 1'b1;
								txCount       <= 4'h0;
								txSum         <= 8'h00;
								state         <= REPLY;
							end else begin
								cmdValid    <= 1'b1;
								busy        <= 1'b1;
								state       <= EXECUTE;
							end
						end else begin
							rxCount <= rxCount + 4'h1;
						end
					end
				end
				EXECUTE: begin
					// Bytes arriving now break the master's ordering; dropped
					// Executor status passes through unchanged
					if (doneValid) begin
						replyStatus <= doneStatus;
						replyValue  <= doneValue;
						txCount     <= 4'h0;
						txSum       <= 8'h00;
						state       <= REPLY;
					end
				end
				REPLY: begin
					txEnable <= 1'b1;
					// A full queue stalls the build; the index moves only on a push
					if (fifoValid && fifoReady) begin
						txSum <= txSum + next_txByte;
						if (txCount == replyLen - 4'h1) begin
							fifoValid <= 1'b0;
							state     <= DRAIN;
						end else begin
							txCount <= txCount + 4'h1;
						end
					end else if (!fifoValid) begin
						fifoValid <= 1'b1;
					end
				end
				DRAIN: begin
					// Release the bus only after the last byte has left
					if (!fifoOutValid) begin
						txEnable <= 1'b0;
						busy     <= 1'b0;
						state    <= RECEIVE;
					end
				end
				default: state <= RECEIVE;
			endcase
		end
	end

	// Reply byte queue towards the transmitter
	// Lets a slow line drain while the reply is built at a byte a cycle
	byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) replyQueue (
		.clock    (clock),
		.reset_n  (reset_n),
		.inValid  (fifoValid),
		.inReady  (fifoReady),
		.inData   (next_txByte),
		.outValid (fifoOutValid),
		.outReady (txReady),
		.outData  (txByte)
	);

	assign txValid = fifoOutValid;
endmodule // motion_command_frame_parser

// *** tb/frame_parser_monitor.sv ***
// Checker for the command frame parser top-level ports.
// Assumes one clock domain and bind by the line after the module.
`timescale 1ns/1ps
module frame_parser_monitor (
	// Clock and reset
	input wire       clock,
	input wire       reset_n,
	// Watched signals
	input wire       cmdValid,
	input wire       checksumError,
	input wire       doneValid,
	input wire       busy,
	input wire       txValid,
	input wire       txReady,
	input wire [7:0] txByte,
	input wire       txEnable
);
	default clocking mc @(posedge clock); endclocking
	default disable iff (!reset_n);
	cmd_pulse_a: assert property (cmdValid |=> !cmdValid)
		else $error("command strobe too long");
	err_pulse_a: assert property (checksumError |=> !checksumError)
		else $error("sum error strobe too long");
	err_no_cmd_a: assert property (checksumError |-> !cmdValid)
		else $error("bad frame passed on");
	err_reply_a: assert property (checksumError |-> ##[0:3] txEnable)
		else $error("no reply to bad frame");
	done_reply_a: assert property (doneValid && busy && !txEnable
		|-> ##2 txEnable)
		else $error("no reply after result");
	tx_enabled_a: assert property (txValid |-> txEnable && busy)
		else $error("byte offered while not replying");
	tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte))
		else $error("reply byte dropped");
	idle_quiet_a: assert property (!busy |-> !txEnable && !txValid)
		else $error("bus driven while idle");
endmodule // frame_parser_monitor
bind motion_command_frame_parser frame_parser_monitor mon (.clock(clock),
	.reset_n(reset_n), .cmdValid(cmdValid), .checksumError(checksumError),
	.doneValid(doneValid), .busy(busy), .txValid(txValid),
	.txReady(txReady), .txByte(txByte), .txEnable(txEnable));

// *** tb/host_model.sv ***
// Host bus master: sends frames, collects reply bytes.
// Assumes the bench waits for each reply before the next send.
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire         clock,
	// Command bytes
	output logic       rxValid,
	output logic [7:0] rxByte,
	// Reply bytes
	input wire         txValid,
	input wire [7:0]   txByte,
	output logic       txReady
);
	logic [7:0] got[$];
	bit         slow;
	initial begin
		rxValid = 1'b0;
		rxByte = 8'h00;
		txReady = 1'b0;
	end
	// Slow mode stalls every other cycle so reply bytes back up in the queue
	always @(posedge clock) begin
		if (txValid && txReady)
			got.push_back(txByte);
		txReady <= slow ? !txReady : 1'b1;
	end
	task send(input bit can, input logic [7:0] adr, ins, typ, axs,
		input logic [31:0] op, input logic [7:0] bad);
		logic [7:0] f[$];
		f = {ins, typ, axs, op[31:24], op[23:16], op[15:8], op[7:0]};
		if (!can) begin
			f.push_front(adr);
			f.push_back(f.sum() + bad);
		end
		foreach (f[i]) begin
			@(posedge clock);
			rxValid <= 1'b1;
			rxByte <= f[i];
		end
		@(posedge clock);
		rxValid <= 1'b0;
		rxByte <= ~rxByte;
	endtask
endmodule // host_model

// *** tb/motion_command_frame_parser_bench.sv ***
// Bench for the command frame parser with host and executor stand-ins.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
module motion_command_frame_parser_bench;
	localparam [7:0] MOD = 8'h05;
	localparam [7:0] REP = 8'h02;
	logic        clock, reset_n, canMode, doneValid;
	logic [7:0]  doneStatus;
	logic [31:0] doneValue;
	wire         rxValid, txValid, txReady, cmdValid, txEnable, busy, sumErr;
	wire  [7:0]  rxByte, txByte, cmdInstruction, cmdType, cmdAxis;
	wire  [31:0] cmdOperand;
	int          n_fail, n_compared, nCmd, nErr;
	motion_command_frame_parser dut (.clock(clock), .reset_n(reset_n),
		.canMode(canMode), .moduleAddress(MOD), .replyAddress(REP),
		.rxValid(rxValid), .rxByte(rxByte), .cmdValid(cmdValid),
		.cmdInstruction(cmdInstruction), .cmdType(cmdType),
		.cmdAxis(cmdAxis), .cmdOperand(cmdOperand), .doneValid(doneValid),
		.doneStatus(doneStatus), .doneValue(doneValue), .txValid(txValid),
		.txReady(txReady), .txByte(txByte), .txEnable(txEnable),
		.busy(busy), .checksumError(sumErr));
	host_model host (.clock(clock), .rxValid(rxValid), .rxByte(rxByte),
		.txValid(txValid), .txByte(txByte), .txReady(txReady));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Executor answers one cycle after each command
	always @(posedge clock) begin
		if (cmdValid === 1'b1)
			nCmd++;
		if (sumErr === 1'b1)
			nErr++;
		doneValid <= cmdValid;
		doneStatus <= 8'h64;
		doneValue <= ~cmdOperand;
	end
	task check(input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task reply(input bit can, input logic [7:0] st, ins, input logic [31:0] v);
		logic [7:0] e[$];
		repeat (3) @(posedge clock);
		for (int i = 0; i < 200 && busy !== 1'b0; i++)
			@(posedge clock);
		e = {MOD, st, ins, v[31:24], v[23:16], v[15:8], v[7:0]};
		if (!can) begin
			e.push_front(REP);
			e.push_back(e.sum());
		end
		check(host.got.size(), e.size());
		foreach (e[i])
			check(host.got[i], e[i]);
		host.got.delete();
	endtask
	task t_good;
		host.slow = 1;
		host.send(0, MOD, 8'h06, 8'h04, 8'h02, 32'h123480FF, 8'h00);
		reply(0, 8'h64, 8'h06, ~32'h123480FF);
		check({cmdInstruction, cmdType, cmdAxis}, 32'h060402);
		check(cmdOperand, 32'h123480FF);
		$display("good frame done");
	endtask
	task t_bad;
		host.slow = 0;
		host.send(0, MOD, 8'h0A, 8'h01, 8'h00, 32'h00000007, 8'h01);
		reply(0, 8'h01, 8'h0A, 32'h00000000);
		check(nCmd, 1);
		check(nErr, 1);
		$display("bad sum done");
	endtask
	task t_other;
		host.send(0, MOD + 8'h01, 8'h06, 8'h00, 8'h00, 32'h1, 8'h00);
		repeat (20) @(posedge clock);
		check(host.got.size(), 0);
		check(busy, 0);
		check(nCmd, 1);
		$display("other address done");
	endtask
	task t_can;
		canMode <= 1'b1;
		host.send(1, 8'h00, 8'h05, 8'h04, 8'h01, 32'hFEDC0001, 8'h00);
		reply(1, 8'h64, 8'h05, ~32'hFEDC0001);
		check(nCmd, 2);
		check(nErr, 1);
		$display("short frame done");
	endtask
	task tally_and_finish;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		reset_n = 1'b0;
		canMode = 1'b0;
		doneValid = 1'b0;
		doneStatus = 8'h00;
		doneValue = 32'h0;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		t_good;
		t_bad;
		t_other;
		t_can;
		tally_and_finish;
	end
	// Three serial frames and one CAN frame need about 3 us
	initial begin
		#50us;
		n_fail++;
		tally_and_finish;
	end
endmodule // motion_command_frame_parser_bench
